// *** logic/ew_map.svh ***
`ifndef EW_MAP_SVH
`define EW_MAP_SVH

// clock
`define EW_CLK_PERIOD_NS 8

// program cycle: a longest time, so the count rounds down
`define EW_PROG_TIME_MS 10
`define EW_PROG_CYCLES ((`EW_PROG_TIME_MS * 1000000) / `EW_CLK_PERIOD_NS)

// fastest link clock period; a quarter of it is a least time, rounded up
`define EW_SCL_PERIOD_NS 10000
`define EW_QTR_CYCLES ((`EW_SCL_PERIOD_NS + 4 * `EW_CLK_PERIOD_NS - 1) / (4 * `EW_CLK_PERIOD_NS))

// link framing
`define EW_BITS_PER_BYTE 4'h8
`define EW_ACK_SLOT 4'h8
`define EW_PAGE_BYTES 16
`define EW_WORD_ADDR_W 8
`define EW_DEV_PIN_CNT 3

// slave address fields
`define EW_SA_TYPE_LSB 4
`define EW_SA_PIN_LSB 1
`define EW_SA_RW_BIT 0

// host register map (AHB-Lite byte addresses)
`define EW_CMD_OFS 32'h0000_0000
`define EW_STAT_OFS 32'h0000_0004

// command register fields
`define EW_CMD_BYTE_LSB 0
`define EW_CMD_OP_LSB 8
`define EW_CMD_ACK_BIT 10

// status register fields
`define EW_ST_BUSY_BIT 0
`define EW_ST_ACK_BIT 1
`define EW_ST_RX_LSB 8

// ahb
`define EW_HTRANS_NONSEQ_BIT 1

`endif

// *** logic/ew_pkg.sv ***
package ew_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_RX = 7'h04,
    ST_ACK = 7'h08,
    ST_TX = 7'h10,
    ST_RACK = 7'h20,
    ST_WAIT = 7'h40
  } ew_dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_STOP = 4'h4,
    H_BYTE = 4'h8
  } ew_host_state_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ = 2'h3
  } ew_op_t;

endpackage : ew_pkg

// *** logic/ew_link_if.sv ***
`timescale 1ns/1ns
interface ew_link_if;
  logic scl;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic mst_sda_out;
  logic mst_sda_oe_n;
  logic sda;

  // open-drain wire with pull-up: low if either end drives its low output
  assign sda = ~((~dev_sda_oe_n & ~dev_sda_out) | (~mst_sda_oe_n & ~mst_sda_out));

  modport dev (
    input scl,
    input sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );

  modport mst (
    output scl,
    input sda,
    output mst_sda_out,
    output mst_sda_oe_n
  );
endinterface : ew_link_if

// *** logic/ew_dev.sv ***
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "ew_map.svh"
// Overview of operation
// - sda changes under scl high mark start/stop
// - ignore bus until a start is seen
// - stop ends transfer, return to idle
// - transmitter releases, receiver acks ninth clock
// - always ack own slave address; no ack here while programming
// - ack every written byte after address
// - read continues after master ack
// - master nack: stop driving, await stop
// - top four address bits hold type code
// - active select pins match address bits
// - remaining address bits select memory block
// - block is sixteen pages of sixteen bytes
// - sixteen bytes programmed in one cycle
// - protect pin high blocks upper-half writes
// - protect pin low allows all writes
// - protected data byte gets no ack
// - master clocks; device never drives scl
// - device only pulls sda low or releases
// - last address bit selects read or write
// - stop after write programs; bus ignored meanwhile
module ew_dev #(
  parameter int PAGE_BITS = 3,
  parameter int PROG_CYCLES = `EW_PROG_CYCLES,
  parameter logic [3:0] TYPE_CODE = 4'h5 // arbitrary value
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // two-wire link
  ew_link_if.dev link,
  // straps
  input wire logic dev_sel_pin_lsb,
  input wire logic dev_sel_pin_mid,
  input wire logic dev_sel_pin_msb,
  input wire logic wp,
  // status
  output logic busy
);
  localparam int MEM_AW = `EW_WORD_ADDR_W + PAGE_BITS;
  localparam int MEM_WORDS = 1 << MEM_AW;
  localparam int PCNT_W = $clog2(PROG_CYCLES + 1);
  // synchronisers
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic [3:0] pin_m, pin_s;
  ew_pkg::ew_dev_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sr_reg;
  logic [7:0] tx_reg;
  logic oe_n_reg;
  logic rw_reg;
  logic data_phase_reg;
  logic ack_seen_reg;
  logic [MEM_AW-1:0] addr_reg;
  logic [7:0] pbuf_reg [`EW_PAGE_BYTES];
  logic [`EW_PAGE_BYTES-1:0] pvalid_reg;
  logic [MEM_AW-5:0] page_base_reg;
  logic armed_reg;
  logic commit_reg;
  logic busy_reg;
  logic [PCNT_W-1:0] pcnt_reg;
  logic [7:0] mem [MEM_WORDS];
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] rd_byte;
  // select pins not in use act as block bits and are ignored here
  function automatic logic addr_match(input logic [7:0] sa, input logic [2:0] pins);
    logic ok;
    ok = (sa[7:`EW_SA_TYPE_LSB] == TYPE_CODE);
    for (int i = 0; i < `EW_DEV_PIN_CNT; i++) begin
      if (i >= PAGE_BITS && sa[i + `EW_SA_PIN_LSB] != pins[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : addr_match
  function automatic logic [MEM_AW-1:0] set_block(input logic [MEM_AW-1:0] a,
                                                  input logic [7:0] sa);
    logic [MEM_AW-1:0] r;
    r = a;
    for (int i = 0; i < PAGE_BITS; i++) begin
      r[`EW_WORD_ADDR_W + i] = sa[i + `EW_SA_PIN_LSB];
    end
    return r;
  endfunction : set_block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      pin_m <= 4'h0;
      pin_s <= 4'h0;
    end else begin
      scl_m <= link.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= link.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      pin_m <= {wp, dev_sel_pin_msb, dev_sel_pin_mid, dev_sel_pin_lsb};
      pin_s <= pin_m;
    end
  end
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
  assign rd_byte = mem[addr_reg];
  // scl is never an output of this end sda output is a constant low
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe_n = oe_n_reg;
  assign busy = busy_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ew_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      sr_reg <= 8'h00;
      tx_reg <= 8'hFF;
      oe_n_reg <= 1'b1;
      rw_reg <= 1'b0;
      data_phase_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      addr_reg <= '0;
      pvalid_reg <= '0;
      page_base_reg <= '0;
      armed_reg <= 1'b0;
      commit_reg <= 1'b0;
      for (int i = 0; i < `EW_PAGE_BYTES; i++) begin
        pbuf_reg[i] <= 8'h00;
      end
    end else if (busy_reg) begin
      // address is not even acknowledged while programming
      state_reg <= ew_pkg::ST_IDLE;
      oe_n_reg <= 1'b1;
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= 1'b0;
      if (stop_det) begin
        state_reg <= ew_pkg::ST_IDLE;
        oe_n_reg <= 1'b1;
        commit_reg <= armed_reg;
        armed_reg <= 1'b0;
      end else if (start_det && state_reg != ew_pkg::ST_WAIT) begin
        // a repeated start drops a page that was never closed by a stop
        state_reg <= ew_pkg::ST_ADDR;
        cnt_reg <= 4'h0;
        oe_n_reg <= 1'b1;
        armed_reg <= 1'b0;
        pvalid_reg <= '0;
      end else begin
        case (state_reg)
          ew_pkg::ST_IDLE, ew_pkg::ST_WAIT: begin
            oe_n_reg <= 1'b1;
          end
          ew_pkg::ST_ADDR, ew_pkg::ST_RX: begin
            if (scl_rise) begin
              sr_reg <= {sr_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == `EW_BITS_PER_BYTE) begin
              cnt_reg <= 4'h0;
              if (state_reg == ew_pkg::ST_ADDR) begin
                if (addr_match(sr_reg, pin_s[2:0])) begin
                  state_reg <= ew_pkg::ST_ACK;
                  oe_n_reg <= 1'b0;
                  rw_reg <= sr_reg[`EW_SA_RW_BIT];
                  addr_reg <= set_block(addr_reg, sr_reg);
                  data_phase_reg <= 1'b0;
                end else begin
                  state_reg <= ew_pkg::ST_IDLE;
                end
              end else if (!data_phase_reg) begin
                // word address inside the selected block
                addr_reg[`EW_WORD_ADDR_W-1:0] <= sr_reg;
                data_phase_reg <= 1'b1;
                state_reg <= ew_pkg::ST_ACK;
                oe_n_reg <= 1'b0;
              end else if (pin_s[3] && addr_reg[MEM_AW-1]) begin
                // upper half is locked: no ack, nothing will be programmed
                state_reg <= ew_pkg::ST_WAIT;
                armed_reg <= 1'b0;
                pvalid_reg <= '0;
              end else begin
                pbuf_reg[addr_reg[3:0]] <= sr_reg;
                pvalid_reg[addr_reg[3:0]] <= 1'b1;
                page_base_reg <= addr_reg[MEM_AW-1:4];
                // only the in-page bits count, so a long burst wraps the page
                addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
                armed_reg <= 1'b1;
                state_reg <= ew_pkg::ST_ACK;
                oe_n_reg <= 1'b0;
              end
            end
          end
          ew_pkg::ST_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                tx_reg <= rd_byte;
                oe_n_reg <= rd_byte[7];
                addr_reg <= addr_reg + 1'b1;
                state_reg <= ew_pkg::ST_TX;
              end else begin
                oe_n_reg <= 1'b1;
                state_reg <= ew_pkg::ST_RX;
              end
              cnt_reg <= 4'h0;
            end
          end
          ew_pkg::ST_TX: begin
            if (scl_rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (cnt_reg == `EW_BITS_PER_BYTE) begin
                oe_n_reg <= 1'b1;
                state_reg <= ew_pkg::ST_RACK;
              end else begin
                oe_n_reg <= tx_reg[6];
                tx_reg <= {tx_reg[6:0], 1'b1};
              end
            end
          end
          ew_pkg::ST_RACK: begin
            if (scl_rise) begin
              ack_seen_reg <= ~sda_s;
            end else if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (ack_seen_reg) begin
                // read address wraps over the whole array
                tx_reg <= rd_byte;
                oe_n_reg <= rd_byte[7];
                addr_reg <= addr_reg + 1'b1;
                state_reg <= ew_pkg::ST_TX;
              end else begin
                state_reg <= ew_pkg::ST_WAIT;
              end
            end
          end
          default: begin
            state_reg <= ew_pkg::ST_IDLE;
            oe_n_reg <= 1'b1;
          end
        endcase
      end
    end
  end
  // the buffered bytes of the page land in one step, as a single program cycle would
  always_ff @(posedge hclk) begin
    if (commit_reg) begin
      for (int i = 0; i < `EW_PAGE_BYTES; i++) begin
        if (pvalid_reg[i]) begin
          mem[{page_base_reg, 4'(i)}] <= pbuf_reg[i];
        end
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg <= 1'b0;
      pcnt_reg <= '0;
    end else if (commit_reg) begin
      busy_reg <= 1'b1;
      pcnt_reg <= PCNT_W'(PROG_CYCLES - 1);
    end else if (busy_reg) begin
      busy_reg <= (pcnt_reg != '0);
      pcnt_reg <= pcnt_reg - 1'b1;
    end
  end
endmodule : ew_dev

// *** logic/ew_host.sv ***
`timescale 1ns/1ns
`include "ew_map.svh"

module ew_host #(
  parameter int QTR_CYCLES = `EW_QTR_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // two-wire link
  ew_link_if.mst link
);

  localparam int QW = $clog2(QTR_CYCLES + 1);

  ew_pkg::ew_host_state_t state_reg;
  ew_pkg::ew_op_t op;
  logic [QW-1:0] qcnt_reg;
  logic tick;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic rd_reg;
  logic ack_out_reg;
  logic ack_in_reg;
  logic scl_reg;
  logic oe_n_reg;
  logic busy_reg;
  logic sda_m, sda_s;
  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic addr_ok;

  assign addr_ok = hsel & hready & htrans[`EW_HTRANS_NONSEQ_BIT];
  assign op = ew_pkg::ew_op_t'(hwdata[`EW_CMD_OP_LSB +: 2]);
  assign tick = (state_reg != ew_pkg::H_IDLE) && (qcnt_reg == QW'(QTR_CYCLES - 1));

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign link.scl = scl_reg;
  assign link.mst_sda_out = 1'b0;
  assign link.mst_sda_oe_n = oe_n_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= link.sda;
      sda_s <= sda_m;
    end
  end

  // bus slave: zero wait states, read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr;
      end
      if (addr_ok && !hwrite && haddr == `EW_STAT_OFS) begin
        hrdata_reg <= 32'h0000_0000;
        hrdata_reg[`EW_ST_BUSY_BIT] <= busy_reg;
        hrdata_reg[`EW_ST_ACK_BIT] <= ack_in_reg;
        hrdata_reg[`EW_ST_RX_LSB +: 8] <= rx_reg;
      end else begin
        hrdata_reg <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qcnt_reg <= '0;
    end else if (state_reg == ew_pkg::H_IDLE || tick) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ew_pkg::H_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      rd_reg <= 1'b0;
      ack_out_reg <= 1'b0;
      ack_in_reg <= 1'b0;
      scl_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else if (state_reg == ew_pkg::H_IDLE) begin
      // a command written while busy is dropped
      if (wr_pend_reg && wr_addr_reg == `EW_CMD_OFS) begin
        busy_reg <= 1'b1;
        phase_reg <= 2'h0;
        bit_reg <= 4'h0;
        tx_reg <= hwdata[`EW_CMD_BYTE_LSB +: 8];
        ack_out_reg <= hwdata[`EW_CMD_ACK_BIT];
        rd_reg <= (op == ew_pkg::OP_READ);
        case (op)
          ew_pkg::OP_START: begin
            state_reg <= ew_pkg::H_START;
          end
          ew_pkg::OP_STOP: begin
            state_reg <= ew_pkg::H_STOP;
          end
          default: begin
            state_reg <= ew_pkg::H_BYTE;
          end
        endcase
      end
    end else if (tick) begin
      phase_reg <= phase_reg + 2'h1;
      case (state_reg)
        ew_pkg::H_START: begin
          // sda falls only with scl high
          case (phase_reg)
            2'h0: oe_n_reg <= 1'b1;
            2'h1: scl_reg <= 1'b1;
            2'h2: oe_n_reg <= 1'b0;
            default: begin
              scl_reg <= 1'b0;
              state_reg <= ew_pkg::H_IDLE;
              busy_reg <= 1'b0;
            end
          endcase
        end
        ew_pkg::H_STOP: begin
          case (phase_reg)
            2'h0: oe_n_reg <= 1'b0;
            2'h1: scl_reg <= 1'b1;
            2'h2: oe_n_reg <= 1'b1;
            default: begin
              state_reg <= ew_pkg::H_IDLE;
              busy_reg <= 1'b0;
            end
          endcase
        end
        ew_pkg::H_BYTE: begin
          case (phase_reg)
            2'h0: begin
              // data moves only while scl is low
              if (bit_reg == `EW_ACK_SLOT) begin
                oe_n_reg <= rd_reg ? ~ack_out_reg : 1'b1;
              end else begin
                oe_n_reg <= rd_reg ? 1'b1 : tx_reg[7];
              end
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: begin
              if (bit_reg == `EW_ACK_SLOT) begin
                ack_in_reg <= ~sda_s;
              end else begin
                rx_reg <= {rx_reg[6:0], sda_s};
              end
            end
            default: begin
              scl_reg <= 1'b0;
              tx_reg <= {tx_reg[6:0], 1'b0};
              if (bit_reg == `EW_ACK_SLOT) begin
                oe_n_reg <= 1'b1;
                state_reg <= ew_pkg::H_IDLE;
                busy_reg <= 1'b0;
              end else begin
                bit_reg <= bit_reg + 4'h1;
              end
            end
          endcase
        end
        default: begin
          state_reg <= ew_pkg::H_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule : ew_host

// *** verification/ew_link_checker.sv ***
`timescale 1ns/1ns
module ew_link_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // two-wire link
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic mst_sda_out,
  input wire logic mst_sda_oe_n
);
  logic scl_q, sda_q, seen_reg, rw_reg;
  logic [3:0] bit_reg, byte_reg;
  wire s_rise = scl & ~scl_q;
  wire start_ev = scl & scl_q & sda_q & ~sda;
  wire stop_ev = scl & scl_q & ~sda_q & sda;
  // device is the transmitter only in data bytes of a read
  wire dev_rd = rw_reg & (byte_reg != 4'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      seen_reg <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        seen_reg <= 1'b1;
      end else if (stop_ev) begin
        seen_reg <= 1'b0;
      end
    end
  end

  // the stop's own clock rise also counts; harmless since bit 0 is never an ack slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_reg <= 4'h0;
      byte_reg <= 4'h0;
      rw_reg <= 1'b0;
    end else if (start_ev) begin
      bit_reg <= 4'h0;
      byte_reg <= 4'h0;
    end else if (s_rise) begin
      bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
      if (bit_reg == 4'h8 && byte_reg != 4'hF) begin
        byte_reg <= byte_reg + 4'h1;
      end
      if (byte_reg == 4'h0 && bit_reg == 4'h7) begin
        rw_reg <= sda;
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence dev_pulls_s;
    s_rise && !dev_sda_oe_n;
  endsequence

  sequence held_low_s;
    !dev_sda_oe_n [*6];
  endsequence

  open_drain_a: assert property (dev_sda_out == 1'b0 && mst_sda_out == 1'b0)
    else $error("sda output value not low");
  clean_change_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device moved sda while scl high");
  idle_reset_a: assert property ($rose(hresetn) |-> scl && sda)
    else $error("link not idle after reset");
  quiet_start_a: assert property (!seen_reg |-> dev_sda_oe_n)
    else $error("device drove sda outside a transfer");
  addr_quiet_a: assert property (s_rise && byte_reg == 4'h0 && bit_reg != 4'h8 |-> dev_sda_oe_n)
    else $error("device drove sda during slave address");
  ack_slot_a: assert property (s_rise && !dev_sda_oe_n && !dev_rd |-> bit_reg == 4'h8)
    else $error("device pulled sda outside the ninth clock");
  mst_release_a: assert property (s_rise && bit_reg == 4'h8 && !dev_rd |-> mst_sda_oe_n)
    else $error("host held sda in the device ack slot");
  dev_release_a: assert property (s_rise && bit_reg == 4'h8 && dev_rd |-> dev_sda_oe_n)
    else $error("device held sda in the host ack slot");
  ack_hold_a: assert property (dev_pulls_s |-> held_low_s)
    else $error("device released sda during scl high");
endmodule : ew_link_checker

// *** verification/test_serial_eeprom_two_wire_slave.sv ***
`timescale 1ns/1ns
module test_serial_eeprom_two_wire_slave;
  localparam logic [3:0] TYPE = 4'h5; // arbitrary value, same as the device default
  localparam int LIMIT = 60000;
  typedef struct {logic [31:0] v; logic [31:0] m;} ew_note_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic pin_mid = 1'b0;
  logic pin_msb = 1'b0;
  logic wp = 1'b0;
  logic chk_en = 1'b0;
  logic hreadyout, hresp, busy;
  logic [31:0] hrdata;
  logic [7:0] ra, d1, d2, d3;
  ew_note_t expq[$];
  ew_note_t note;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 hclk = ~hclk;

  ew_link_if link();
  ew_host #(.QTR_CYCLES(8)) u_ew_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
  ew_dev #(.PAGE_BITS(1), .PROG_CYCLES(2000), .TYPE_CODE(TYPE)) u_ew_dev (.hclk(hclk),
    .hresetn(hresetn), .link(link), .dev_sel_pin_lsb(1'b0), .dev_sel_pin_mid(pin_mid),
    .dev_sel_pin_msb(pin_msb), .wp(wp), .busy(busy));
  ew_link_checker u_ew_link_checker (.hclk(hclk), .hresetn(hresetn), .scl(link.scl),
    .sda(link.sda), .dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n),
    .mst_sda_out(link.mst_sda_out), .mst_sda_oe_n(link.mst_sda_oe_n));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      input logic chk, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    chk_en <= chk;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk_en <= 1'b0;
  endtask : ahb

  task automatic expect_rd(input logic [31:0] a, input logic [31:0] v, input logic [31:0] m);
    logic [31:0] r;
    expq.push_back('{v: v, m: m});
    ahb(1'b0, a, 32'h0, 1'b1, r);
  endtask : expect_rd

  // one link operation, then wait until the host reports it finished
  task automatic op(input ew_pkg::ew_op_t o, input logic [7:0] b, input logic ak);
    logic [31:0] r;
    ahb(1'b1, 32'h0, {21'h0, ak, o, b}, 1'b0, r);
    r = 32'h1;
    while (r[0] !== 1'b0) ahb(1'b0, 32'h4, 32'h0, 1'b0, r);
  endtask : op

  function automatic logic [7:0] sa(input logic blk, input logic rw);
    return {TYPE, pin_msb, pin_mid, blk, rw};
  endfunction : sa

  task automatic wr_b(input logic [7:0] b, input logic ak);
    op(ew_pkg::OP_WRITE, b, 1'b0);
    expect_rd(32'h4, {30'h0, ak, 1'b0}, 32'h2);
  endtask : wr_b

  task automatic rd_b(input logic ak, input logic [7:0] b);
    op(ew_pkg::OP_READ, 8'h00, ak);
    expect_rd(32'h4, {16'h0, b, 8'h0}, 32'hFF00);
  endtask : rd_b

  task automatic edge_op(input logic stop);
    op(stop ? ew_pkg::OP_STOP : ew_pkg::OP_START, 8'h00, 1'b0);
  endtask : edge_op

  // dummy write of the word address, repeated start, read direction
  task automatic rd_at(input logic blk, input logic [7:0] a);
    edge_op(1'b0);
    wr_b(sa(blk, 1'b0), 1'b1);
    wr_b(a, 1'b1);
    edge_op(1'b0);
    wr_b(sa(blk, 1'b1), 1'b1);
  endtask : rd_at

  // address polling until the program cycle is over
  task automatic poll_ready(input logic blk);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 20 && r[1] !== 1'b1; i++) begin
      edge_op(1'b0);
      op(ew_pkg::OP_WRITE, sa(blk, 1'b0), 1'b0);
      ahb(1'b0, 32'h4, 32'h0, 1'b0, r);
      edge_op(1'b1);
    end
    // the last poll must have been acknowledged, else the program cycle never ended
    expect_rd(32'h4, 32'h2, 32'h2);
  endtask : poll_ready

  always @(posedge hclk) begin
    if (chk_en === 1'b1 && expq.size() > 0) begin
      note = expq.pop_front();
      check(hrdata & note.m, note.v);
    end
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      $display("MISMATCH at %0t: run did not finish", $time);
      summarize();
    end
  end

  initial begin
    void'($urandom(50));
    ra = 8'($urandom) & 8'hFE;
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    d3 = ~d1;
    @(posedge hclk);
    pin_mid <= 1'($urandom);
    pin_msb <= 1'($urandom);
    repeat (19) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    expect_rd(32'h4, 32'h0, 32'hFFFF_FFFF);
    expect_rd(32'h8, 32'h0, 32'hFFFF_FFFF);
    $display("test reset done");
    edge_op(1'b0);
    wr_b(sa(1'b1, 1'b0), 1'b1);
    wr_b(ra, 1'b1);
    wr_b(d1, 1'b1);
    wr_b(d2, 1'b1);
    edge_op(1'b1);
    edge_op(1'b0);
    wr_b(sa(1'b1, 1'b0), 1'b0);
    edge_op(1'b1);
    check({31'h0, busy}, 32'h1);
    poll_ready(1'b1);
    $display("test page write done");
    wp <= 1'b1;
    rd_at(1'b1, ra);
    rd_b(1'b1, d1);
    rd_b(1'b0, d2);
    edge_op(1'b1);
    $display("test sequential read done");
    edge_op(1'b0);
    wr_b(sa(1'b1, 1'b0), 1'b1);
    wr_b(ra, 1'b1);
    wr_b(d3, 1'b0);
    edge_op(1'b1);
    edge_op(1'b0);
    wr_b(sa(1'b1, 1'b0), 1'b1);
    edge_op(1'b1);
    rd_at(1'b1, ra);
    rd_b(1'b0, d1);
    edge_op(1'b1);
    $display("test protected write done");
    edge_op(1'b0);
    wr_b(sa(1'b0, 1'b0), 1'b1);
    wr_b(ra, 1'b1);
    wr_b(d3, 1'b1);
    edge_op(1'b1);
    poll_ready(1'b0);
    rd_at(1'b0, ra);
    rd_b(1'b0, d3);
    edge_op(1'b1);
    $display("test lower block done");
    edge_op(1'b0);
    wr_b({TYPE ^ 4'h1, pin_msb, pin_mid, 2'h0}, 1'b0);
    edge_op(1'b1);
    edge_op(1'b0);
    wr_b(sa(1'b0, 1'b0) ^ 8'h08, 1'b0);
    edge_op(1'b1);
    $display("test address mismatch done");
    summarize();
  end
endmodule : test_serial_eeprom_two_wire_slave
